/* rtl/tw_pkg.sv */
// constants and types shared by the timer2 / timebase / wave-out block
package tw_pkg;
    localparam logic [7:0] ADDR_INT_FLAGS  = 8'h95;
    localparam logic [7:0] ADDR_PIN_MODE   = 8'hA6;
    localparam logic [7:0] ADDR_T2_CTRL    = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LO  = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI  = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO   = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI   = 8'hCD;
    localparam logic [7:0] ADDR_AUXILIARY_CONTROL_THREE       = 8'hEF;
    localparam logic [7:0] ADDR_AUXILIARY_CONTROL_ONE       = 8'hF8;
    localparam int         TB_FLAG_BIT     = 0;
    localparam logic [7:0] TB_FLAG_CLR_CMD = 8'hFE;
    localparam int         T2_WAVE_EN_BIT  = 4;
    localparam int         T0_WAVE_EN_BIT  = 0;
    localparam int         TB_RATE_LSB     = 3;
    localparam int         TB_CLEAR_BIT    = 6;
    localparam int         T2_INPUT_SEL_BIT = 2;
    localparam int         TB_BASE_PERIOD  = 32768;
    localparam int         SLOW_DIV        = 16;
    localparam int         T0_WAVE_DIV     = 64;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [15:0] T2_COUNT_MAX   = 16'hFFFF;

    typedef struct packed {
        logic ovf_flag;
        logic ext_flag;
        logic uart_receive_clock_select;
        logic uart_transmit_clock_select;
        logic trig_en;
        logic run;
        logic counter_sel;
        logic capture_sel;
    } tw_t2ctl_s;

    typedef struct packed {
        logic count_pin;
        logic trig_pin;
        logic slow_clk;
    } tw_pins_s;
endpackage

/* rtl/tw_timer_block.sv */
// timer2 with reload/capture, slow-clock timebase and buzzer wave outputs
`timescale 1ns/1ps
// Overview of operation
// RULE_01: timer2 count and reload value are four software read/write bytes
// RULE_02: counter input select bit picks count pin (0) or slow clock / 16 (1)
// RULE_03: run bit set: count every 2 clocks, or on input falling edge; else hold
// RULE_04: overflow sets flag unless baud clock use; reload mode reloads count
// RULE_05: trigger falling edge sets external flag, reloads or captures per mode
// RULE_06: timebase runs freely and raises its flag periodically
// RULE_07: timebase counts only the slow clock
// RULE_08: rate field code 000 gives 32768 slow cycles, halving to 256 at 111
// RULE_09: timebase flag sets when count reaches the selected number of cycles
// RULE_10: timebase flag clears when the cpu enters its service routine
// RULE_11: writing FEh to the interrupt flag register clears the timebase flag
// RULE_12: timebase clear bit resets the count and self-clears one cycle later
// RULE_13: timer0 wave output is timer0 overflows divided by 64
// RULE_14: timer2 wave output toggles on each timer2 overflow
// RULE_15: wave frequency follows overflow rate, hence the reload value
// RULE_16: timer2 wave drives its pin only while its enable bit is 1
// RULE_17: timer0 wave drives its pin only while its enable bit is 1
module tw_timer_block #(
    parameter int TB_BASE_PERIOD = tw_pkg::TB_BASE_PERIOD
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       T2_COUNT_PIN_IN,
    input  wire logic       T2_TRIG_PIN_IN,
    input  wire logic       SLOW_CLK_IN,
    input  wire logic       T0_OVF_PULSE,
    input  wire logic       TB_ISR_ENTER,
    output logic            T2_OVF_PULSE,
    output logic            T2_OVF_FLAG,
    output logic            T2_EXT_FLAG,
    output logic            TB_INT_FLAG,
    output logic            UART_RX_CLK_SEL,
    output logic            UART_TX_CLK_SEL,
    output logic            T2_WAVE_OUT,
    output logic            T2_WAVE_OE_N,
    output logic            T0_WAVE_OUT,
    output logic            T0_WAVE_OE_N
);
    localparam int TBW = $clog2(TB_BASE_PERIOD);
    localparam int SDW = $clog2(tw_pkg::SLOW_DIV);
    localparam int T0W = $clog2(tw_pkg::T0_WAVE_DIV);

    logic [1:0]        rst_sync_reg;
    logic              rst_n_int;
    tw_pkg::tw_pins_s  s1_reg, s2_reg, s3_reg;
    tw_pkg::tw_t2ctl_s ctl_reg, ctl_next;
    logic [15:0]       cnt_reg, cnt_next;
    logic [15:0]       rld_reg, rld_next;
    logic              pre_reg, pre_next;
    logic              ovf_reg, ovf_next;
    logic [SDW-1:0]    sdiv_reg, sdiv_next;
    logic [TBW-1:0]    tb_cnt_reg, tb_cnt_next;
    logic              tb_flag_reg, tb_flag_next;
    logic              tb_clr_reg, tb_clr_next;
    logic [2:0]        rate_reg, rate_next;
    logic              src_sel_reg, src_sel_next;
    logic              t2_wen_reg, t2_wen_next;
    logic              t0_wen_reg, t0_wen_next;
    logic              t2_wave_reg, t2_wave_next;
    logic [T0W-1:0]    t0_div_reg, t0_div_next;
    logic              t2_out_reg, t2_out_next, t0_out_reg, t0_out_next;
    logic              t2_oe_n_reg, t2_oe_n_next, t0_oe_n_reg, t0_oe_n_next;
    logic [7:0]        rdata_next;
    logic              wr_ctl, wr_clo, wr_chi, wr_rlo, wr_rhi;
    logic              wr_int, wr_pin, wr_auxiliary_control_three, wr_auxiliary_control_one, wr_cnt;
    logic              slow_tick, slow16_fall, pin_fall, trig_fall;
    logic              baud, inc, trig;
    logic [TBW-1:0]    tb_last;

    // reset release
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_reg[1];

    // pin synchronisers, third stage for edges
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= {T2_COUNT_PIN_IN, T2_TRIG_PIN_IN, SLOW_CLK_IN};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign slow_tick   = s2_reg.slow_clk & ~s3_reg.slow_clk;
    assign slow16_fall = slow_tick && (sdiv_reg == SDW'(tw_pkg::SLOW_DIV - 1)); // RULE_02
    assign pin_fall    = s3_reg.count_pin & ~s2_reg.count_pin;
    assign trig_fall   = s3_reg.trig_pin & ~s2_reg.trig_pin;

    assign wr_ctl  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_T2_CTRL);
    assign wr_clo  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_COUNT_LO);
    assign wr_chi  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_COUNT_HI);
    assign wr_rlo  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_RELOAD_LO);
    assign wr_rhi  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_RELOAD_HI);
    assign wr_int  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_INT_FLAGS);
    assign wr_pin  = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_PIN_MODE);
    assign wr_auxiliary_control_three = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_AUXILIARY_CONTROL_THREE);
    assign wr_auxiliary_control_one = SFR_WR && (SFR_ADDR == tw_pkg::ADDR_AUXILIARY_CONTROL_ONE);
    assign wr_cnt  = wr_clo | wr_chi;

    assign baud = ctl_reg.uart_receive_clock_select | ctl_reg.uart_transmit_clock_select;
    assign trig = ctl_reg.trig_en & trig_fall; // RULE_05
    assign inc  = ctl_reg.run &
                  (ctl_reg.counter_sel ? (src_sel_reg ? slow16_fall : pin_fall) // RULE_02
                                       : pre_reg); // RULE_03

    // timer2 next state
    always_comb begin
        ctl_next = ctl_reg;
        cnt_next = cnt_reg;
        rld_next = rld_reg;
        ovf_next = 1'b0;
        pre_next = ctl_reg.run & ~ctl_reg.counter_sel & ~pre_reg; // RULE_03
        if (wr_ctl) begin
            ctl_next = tw_pkg::tw_t2ctl_s'(SFR_WDATA); // RULE_01
        end
        if (wr_clo) begin
            cnt_next[7:0] = SFR_WDATA; // RULE_01
        end
        if (wr_chi) begin
            cnt_next[15:8] = SFR_WDATA; // RULE_01
        end
        if (wr_rlo) begin
            rld_next[7:0] = SFR_WDATA; // RULE_01
        end
        if (wr_rhi) begin
            rld_next[15:8] = SFR_WDATA; // RULE_01
        end
        if (inc && !wr_cnt) begin
            if (cnt_reg == tw_pkg::T2_COUNT_MAX) begin
                ovf_next = 1'b1;
                cnt_next = (!ctl_reg.capture_sel || baud) ? rld_reg : 16'h0000; // RULE_04
            end else begin
                cnt_next = cnt_reg + 16'h0001; // RULE_03
            end
        end
        if (trig) begin
            ctl_next.ext_flag = 1'b1; // RULE_05
            if (ctl_reg.capture_sel) begin
                rld_next = cnt_reg; // RULE_05
            end else if (!wr_cnt) begin
                cnt_next = rld_reg; // RULE_05
            end
        end
        if (ovf_next && !baud) begin
            ctl_next.ovf_flag = 1'b1; // RULE_04
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            ctl_reg <= tw_pkg::tw_t2ctl_s'(tw_pkg::REG_RESET);
            cnt_reg <= 16'h0000;
            rld_reg <= 16'h0000;
            ovf_reg <= 1'b0;
            pre_reg <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            cnt_reg <= cnt_next;
            rld_reg <= rld_next;
            ovf_reg <= ovf_next;
            pre_reg <= pre_next;
        end
    end

    // timebase and configuration next state
    // short periods floor at one slow cycle instead of wrapping
    assign tb_last = ((TB_BASE_PERIOD >> rate_reg) > 1) ?
                     TBW'((TB_BASE_PERIOD >> rate_reg) - 1) : '0; // RULE_08

    always_comb begin
        rate_next    = rate_reg;
        src_sel_next = src_sel_reg;
        t2_wen_next  = t2_wen_reg;
        t0_wen_next  = t0_wen_reg;
        tb_clr_next  = wr_auxiliary_control_one & SFR_WDATA[tw_pkg::TB_CLEAR_BIT]; // RULE_12
        tb_cnt_next  = tb_cnt_reg;
        tb_flag_next = tb_flag_reg;
        sdiv_next    = slow_tick ? sdiv_reg + SDW'(1) : sdiv_reg;
        if (wr_auxiliary_control_three) begin
            rate_next = SFR_WDATA[tw_pkg::TB_RATE_LSB +: 3]; // RULE_08
        end
        if (wr_auxiliary_control_one) begin
            src_sel_next = SFR_WDATA[tw_pkg::T2_INPUT_SEL_BIT]; // RULE_02
        end
        if (wr_pin) begin
            t2_wen_next = SFR_WDATA[tw_pkg::T2_WAVE_EN_BIT]; // RULE_16
            t0_wen_next = SFR_WDATA[tw_pkg::T0_WAVE_EN_BIT]; // RULE_17
        end
        if (TB_ISR_ENTER || (wr_int && SFR_WDATA == tw_pkg::TB_FLAG_CLR_CMD)) begin
            tb_flag_next = 1'b0; // RULE_10 RULE_11
        end
        if (tb_clr_reg) begin
            tb_cnt_next = '0; // RULE_12
        end else if (slow_tick) begin // RULE_07
            if (tb_cnt_reg >= tb_last) begin
                tb_cnt_next  = '0; // RULE_06
                tb_flag_next = 1'b1; // RULE_09
            end else begin
                tb_cnt_next = tb_cnt_reg + TBW'(1);
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            rate_reg    <= 3'h0;
            src_sel_reg <= 1'b0;
            t2_wen_reg  <= 1'b0;
            t0_wen_reg  <= 1'b0;
            tb_clr_reg  <= 1'b0;
            tb_cnt_reg  <= '0;
            tb_flag_reg <= 1'b0;
            sdiv_reg    <= '0;
        end else begin
            rate_reg    <= rate_next;
            src_sel_reg <= src_sel_next;
            t2_wen_reg  <= t2_wen_next;
            t0_wen_reg  <= t0_wen_next;
            tb_clr_reg  <= tb_clr_next;
            tb_cnt_reg  <= tb_cnt_next;
            tb_flag_reg <= tb_flag_next;
            sdiv_reg    <= sdiv_next;
        end
    end

    // wave dividers and read mux
    always_comb begin
        t2_wave_next = ovf_reg ? ~t2_wave_reg : t2_wave_reg; // RULE_14 RULE_15
        t0_div_next  = T0_OVF_PULSE ? t0_div_reg + T0W'(1) : t0_div_reg; // RULE_13
        t2_out_next  = t2_wen_reg & t2_wave_reg; // RULE_16
        t0_out_next  = t0_wen_reg & t0_div_reg[T0W-1]; // RULE_17
        t2_oe_n_next = ~t2_wen_next; // RULE_16
        t0_oe_n_next = ~t0_wen_next; // RULE_17
        case (SFR_ADDR)
            tw_pkg::ADDR_INT_FLAGS: rdata_next = {7'h00, tb_flag_reg};
            tw_pkg::ADDR_PIN_MODE:  rdata_next = {3'h0, t2_wen_reg, 3'h0, t0_wen_reg};
            tw_pkg::ADDR_T2_CTRL:   rdata_next = ctl_reg;
            tw_pkg::ADDR_RELOAD_LO: rdata_next = rld_reg[7:0];
            tw_pkg::ADDR_RELOAD_HI: rdata_next = rld_reg[15:8];
            tw_pkg::ADDR_COUNT_LO:  rdata_next = cnt_reg[7:0];
            tw_pkg::ADDR_COUNT_HI:  rdata_next = cnt_reg[15:8];
            tw_pkg::ADDR_AUXILIARY_CONTROL_THREE:      rdata_next = {2'h0, rate_reg, 3'h0};
            tw_pkg::ADDR_AUXILIARY_CONTROL_ONE:      rdata_next = {1'b0, tb_clr_reg, 3'h0, src_sel_reg, 2'h0};
            default:                rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            t2_wave_reg <= 1'b0;
            t0_div_reg  <= '0;
            t2_out_reg  <= 1'b0;
            t0_out_reg  <= 1'b0;
            t2_oe_n_reg <= 1'b1;
            t0_oe_n_reg <= 1'b1;
            SFR_RDATA   <= 8'h00;
        end else begin
            t2_wave_reg <= t2_wave_next;
            t0_div_reg  <= t0_div_next;
            t2_out_reg  <= t2_out_next;
            t0_out_reg  <= t0_out_next;
            t2_oe_n_reg <= t2_oe_n_next;
            t0_oe_n_reg <= t0_oe_n_next;
            SFR_RDATA   <= rdata_next;
        end
    end

    assign T2_OVF_PULSE    = ovf_reg;
    assign T2_OVF_FLAG     = ctl_reg.ovf_flag;
    assign T2_EXT_FLAG     = ctl_reg.ext_flag;
    assign TB_INT_FLAG     = tb_flag_reg;
    assign UART_RX_CLK_SEL = ctl_reg.uart_receive_clock_select;
    assign UART_TX_CLK_SEL = ctl_reg.uart_transmit_clock_select;
    assign T2_WAVE_OUT     = t2_out_reg;
    assign T2_WAVE_OE_N    = t2_oe_n_reg;
    assign T0_WAVE_OUT     = t0_out_reg;
    assign T0_WAVE_OE_N    = t0_oe_n_reg;

    a_t2_reload_ovf: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_04
        (inc && !wr_cnt && !trig && !ctl_reg.capture_sel && cnt_reg == 16'hFFFF)
        |=> (cnt_reg == $past(rld_reg)) && ovf_reg)
        else $error("timer2 reload on overflow failed");
    a_t2_ovf_flag: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_04
        (ovf_next && !baud) |=> ctl_reg.ovf_flag)
        else $error("timer2 overflow flag not set");
    a_t2_ext_capture: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_05
        (trig && ctl_reg.capture_sel) |=> (rld_reg == $past(cnt_reg)) && ctl_reg.ext_flag)
        else $error("timer2 capture failed");
    a_t2_hold_stop: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_03
        (!ctl_reg.run && !wr_cnt && !trig) |=> $stable(cnt_reg))
        else $error("timer2 moved while stopped");
    a_t2_half_rate: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_03
        (ctl_reg.run && !ctl_reg.counter_sel && !wr_cnt && !trig && !wr_ctl
         && cnt_reg < 16'hFFF0) ##1 (!wr_cnt && !trig && !wr_ctl)
        |=> cnt_reg == $past(cnt_reg, 2) + 16'h0001)
        else $error("timer2 not counting every two clocks");
    a_tb_period_flag: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_09
        (slow_tick && !tb_clr_reg && tb_cnt_reg >= tb_last) |=> tb_flag_reg && tb_cnt_reg == '0)
        else $error("timebase flag not set at period end");
    a_tb_clear_bit: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_12
        (wr_auxiliary_control_one && SFR_WDATA[tw_pkg::TB_CLEAR_BIT]) ##1 !wr_auxiliary_control_one
        |=> !tb_clr_reg && tb_cnt_reg == '0)
        else $error("timebase clear bit misbehaved");
    a_tb_sw_clear: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_11
        (wr_int && SFR_WDATA == tw_pkg::TB_FLAG_CLR_CMD && !slow_tick) |=> !tb_flag_reg)
        else $error("timebase flag not cleared by write");
    a_tb_isr_clear: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_10
        (TB_ISR_ENTER && !slow_tick) |=> !tb_flag_reg)
        else $error("timebase flag not cleared on service entry");
    a_t2_wave_toggle: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int) // RULE_14
        ovf_reg |=> t2_wave_reg != $past(t2_wave_reg))
        else $error("timer2 wave did not toggle");
endmodule

/* verif/tw_cpu_model.sv */
// cpu-side model that drives the special function register bus
`timescale 1ns/1ps
module tw_cpu_model (
    input  wire logic       clk,
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata,
    output logic            isr_enter
);
    initial begin
        sfr_addr  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_wdata = 8'h00;
        isr_enter = 1'b0;
    end
    // one write, strobe for exactly one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        sfr_wdata <= ~d;
    endtask
    // read data is registered one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        @(posedge clk);
        #1;
        d = sfr_rdata;
    endtask
    // vectoring into the timebase service routine
    task automatic isr();
        @(posedge clk);
        isr_enter <= 1'b1;
        @(posedge clk);
        isr_enter <= 1'b0;
    endtask
endmodule

/* verif/tw_timer_block_tb_top.sv */
// self-checking bench for the timer2, timebase and wave-out block
`timescale 1ns/1ps
module tw_timer_block_tb_top;
    localparam int TBP = 64;
    logic       clk, rst_n, wr_s, cnt_pin, trig_pin, slow, t0_ovf, isr, b;
    logic [7:0] addr, wdata, rdata, v, v2;
    logic       ovf_p, ovf_f, ext_f, tb_f, rx_s, tx_s, w2, w2_n, w0, w0_n;
    int         bad_count, checks, n, p;
    logic [7:0] ra [14] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC8, 8'hC8, 8'hA6,
                            8'hA6, 8'hEF, 8'hEF, 8'hF8, 8'hF8, 8'h95, 8'h40};
    logic [7:0] rw [14] = '{8'h5A, 8'hA5, 8'h12, 8'h34, 8'hEB, 8'h00, 8'hFF,
                            8'h00, 8'hFF, 8'h00, 8'h04, 8'h00, 8'h55, 8'h77};
    logic [7:0] re [14] = '{8'h5A, 8'hA5, 8'h12, 8'h34, 8'hEB, 8'h00, 8'h11,
                            8'h00, 8'h38, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    tw_timer_block #(.TB_BASE_PERIOD(TBP)) tw_timer_block_i (
        .CORE_CLK        (clk),
        .RST_N           (rst_n),
        .SFR_ADDR        (addr),
        .SFR_WR          (wr_s),
        .SFR_WDATA       (wdata),
        .SFR_RDATA       (rdata),
        .T2_COUNT_PIN_IN (cnt_pin),
        .T2_TRIG_PIN_IN  (trig_pin),
        .SLOW_CLK_IN     (slow),
        .T0_OVF_PULSE    (t0_ovf),
        .TB_ISR_ENTER    (isr),
        .T2_OVF_PULSE    (ovf_p),
        .T2_OVF_FLAG     (ovf_f),
        .T2_EXT_FLAG     (ext_f),
        .TB_INT_FLAG     (tb_f),
        .UART_RX_CLK_SEL (rx_s),
        .UART_TX_CLK_SEL (tx_s),
        .T2_WAVE_OUT     (w2),
        .T2_WAVE_OE_N    (w2_n),
        .T0_WAVE_OUT     (w0),
        .T0_WAVE_OE_N    (w0_n)
    );
    tw_cpu_model tw_cpu_model_i (
        .clk       (clk),
        .sfr_addr  (addr),
        .sfr_wr    (wr_s),
        .sfr_wdata (wdata),
        .sfr_rdata (rdata),
        .isr_enter (isr)
    );
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("counts: %0d checks, %0d mismatches", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        tw_cpu_model_i.wr(a, d);
    endtask
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        tw_cpu_model_i.rd(a, d);
    endtask
    task automatic edges(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_pulse(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (ovf_p !== 1'b1 && c < 300);
        if (ovf_p !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask
    task automatic pin_fall(input bit trig);
        @(posedge clk);
        if (trig) trig_pin <= 1'b0; else cnt_pin <= 1'b0;
        repeat (4) @(posedge clk);
        if (trig) trig_pin <= 1'b1; else cnt_pin <= 1'b1;
        edges(4);
    endtask
    task automatic tick();
        @(posedge clk);
        slow <= 1'b1;
        repeat (4) @(posedge clk);
        slow <= 1'b0;
        edges(6);
    endtask
    task automatic t0p();
        @(posedge clk);
        t0_ovf <= 1'b1;
        @(posedge clk);
        t0_ovf <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #4000000;
        bad_count++;
        end_sim();
    end
    initial begin
        {rst_n, slow, t0_ovf} = 3'b000;
        {cnt_pin, trig_pin} = 2'b11;
        {bad_count, checks} = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        edges(3);
        chk({w2_n, w0_n, ovf_f, ext_f, tb_f, w2, w0}, 7'b1100000);
        for (int i = 0; i < 14; i++) begin
            rd8(ra[i], v);
            chk(v, 8'h00);
        end
        $display("test reset done");
        for (int i = 0; i < 14; i++) begin
            w(ra[i], rw[i]);
            rd8(ra[i], v);
            chk(v, re[i]);
        end
        $display("test register rows done");
        w(8'hCA, 8'hF0); w(8'hCB, 8'hFF); w(8'hCC, 8'hFC); w(8'hCD, 8'hFF);
        w(8'hA6, 8'h10); w(8'hC8, 8'h04);
        wait_pulse(n);
        chk(ovf_f, 1'b1);
        b = w2;
        wait_pulse(n);
        chk(16'(n), 16'h0020);
        chk({w2, w2_n}, {~b, 1'b0});
        w(8'hC8, 8'h20);
        w(8'hC8, 8'h24);
        wait_pulse(n);
        edges(2);
        chk({rx_s, tx_s, ovf_f}, 3'h4);
        w(8'hC8, 8'h10);
        w(8'hC8, 8'h14);
        wait_pulse(n);
        edges(2);
        chk({rx_s, tx_s, ovf_f}, 3'h2);
        w(8'hC8, 8'h00); rd8(8'hCC, v); rd8(8'hCC, v2);
        chk(v, v2);
        $display("test timer mode done");
        w(8'hCC, 8'h00); w(8'hCD, 8'h00); w(8'hF8, 8'h00); w(8'hC8, 8'h06);
        repeat (5) pin_fall(0);
        rd8(8'hCC, v);
        chk(v, 8'h05);
        w(8'hF8, 8'h04);
        pin_fall(0);
        repeat (32) tick();
        rd8(8'hCC, v);
        chk(v, 8'h07);
        $display("test counter mode done");
        w(8'hC8, 8'h00); w(8'hCC, 8'h34); w(8'hCD, 8'h12); w(8'hC8, 8'h09);
        pin_fall(1);
        rd8(8'hCA, v); rd8(8'hCB, v2);
        chk(ext_f, 1'h1);
        chk({v2, v}, 16'h1234);
        w(8'hC8, 8'h08); w(8'hCA, 8'h78); w(8'hCB, 8'h56);
        pin_fall(1);
        rd8(8'hCC, v); rd8(8'hCD, v2);
        chk(ext_f, 1'h1);
        chk({v2, v}, 16'h5678);
        w(8'hC8, 8'h00);
        pin_fall(1);
        chk(ext_f, 1'b0);
        $display("test trigger done");
        for (int k = 0; k < 8; k++) begin
            p = (TBP >> k) > 0 ? (TBP >> k) : 1;
            w(8'hEF, 8'(k << 3)); w(8'hF8, 8'h40); w(8'h95, 8'hFE);
            repeat (p - 1) tick();
            chk(tb_f, 1'b0);
            tick();
            chk(tb_f, 1'b1);
            w(8'h95, 8'h01); rd8(8'h95, v);
            chk(v, 8'h01);
            w(8'h95, 8'hFE); rd8(8'h95, v);
            chk(v, 8'h00);
        end
        rd8(8'hF8, v);
        chk(v, 8'h00);
        tick();
        chk(tb_f, 1'h1);
        tw_cpu_model_i.isr();
        #1;
        chk(tb_f, 1'b0);
        $display("test timebase done");
        w(8'hA6, 8'h01);
        repeat (31) t0p();
        edges(2);
        chk({w0, w0_n}, 2'b00);
        t0p();
        edges(2);
        chk({w0, w0_n}, 2'b10);
        w(8'hA6, 8'h00);
        edges(2);
        chk({w0, w0_n, w2, w2_n}, 4'b0101);
        $display("test wave outputs done");
        @(posedge clk);
        rst_n <= 1'b0;
        edges(2);
        chk({w2_n, w0_n, ovf_f, ext_f, tb_f, w2, w0}, 7'h60);
        @(posedge clk);
        rst_n <= 1'b1;
        edges(3);
        rd8(8'hCC, v);
        chk(v, 8'h00);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
